// ### src/rtc_pkg.sv
// Shared constants and types for both ends of the clock bus.
package rtc_pkg;

  // Data bus width in bits.
  localparam int DW = 4;

  // Register addresses; A_BANK is seen in every bank.
  localparam logic [3:0] A_SEC_U = 4'h0;
  localparam logic [3:0] A_SEC_T = 4'h1;
  localparam logic [3:0] A_MIN_U = 4'h2;
  localparam logic [3:0] A_MIN_T = 4'h3;
  localparam logic [3:0] A_CTRL = 4'hD;
  localparam logic [3:0] A_TMR = 4'hE;
  localparam logic [3:0] A_BANK = 4'hF;
  localparam logic [1:0] BANK_TIME = 2'h0;

  // Field positions in the control and timer registers.
  localparam int B_HALT = 0;
  localparam int B_ADJ = 1;
  localparam int B_BUSY = 2;
  localparam int B_FAIL = 3;
  localparam int B_TMR_EN = 0;
  localparam logic [3:0] D_HALT = 4'(1 << B_HALT);
  localparam logic [3:0] D_ADJ = 4'(1 << B_ADJ);

  // Reset values.
  localparam logic RST_HALT = 1'b1;
  localparam logic RST_FAIL = 1'b1;
  localparam logic RST_CS_N = 1'b1;

  // Clock rates and times in their own units.
  localparam int CLK_HZ = 100_000_000;
  localparam int OSC_HZ = 32768;
  localparam int BUSY_US = 244;
  localparam int PWRUP_MS = 50;
  localparam int HALT_WAIT_US = 122;
  localparam int POLL_TO_US = 750;
  localparam int OSC_SETTLE_MS = 1000;

  // Derived counts: oscillator ticks or system clock cycles.
  localparam int BUSY_TICKS = BUSY_US * OSC_HZ / 1_000_000;
  localparam int PWRUP_CYC = PWRUP_MS * (CLK_HZ / 1000);
  localparam int HALT_WAIT_CYC = HALT_WAIT_US * (CLK_HZ / 1_000_000);
  localparam int POLL_TO_CYC = POLL_TO_US * (CLK_HZ / 1_000_000);
  localparam int OSC_SETTLE_CYC = OSC_SETTLE_MS * (CLK_HZ / 1000);

  // Host sequencer states.
  typedef enum logic [4:0] {
    HS_PWR = 5'h01,
    HS_IDLE = 5'h02,
    HS_WR = 5'h04,
    HS_RD = 5'h08,
    HS_WT = 5'h10
  } rtc_hst_t;

endpackage

// ### src/rtc_bus_if.sv
// Parallel bus between the host and the clock device.
`timescale 1ns/100ps
interface rtc_bus_if;
  import rtc_pkg::*;
  logic cs_n;
  logic cs_hi;
  logic wr_n;
  logic rd_n;
  logic [3:0] addr;
  logic [DW-1:0] h_d;
  logic h_oe;
  logic [DW-1:0] d_d;
  logic d_oe;
  logic [DW-1:0] data;

  // Shared data wire level worked out from both enables.
  assign data = h_oe ? h_d : (d_oe ? d_d : '0);

  modport host (
    output cs_n, cs_hi, wr_n, rd_n, addr, h_d, h_oe,
    input data
  );
  modport dev (
    input cs_n, cs_hi, wr_n, rd_n, addr, data,
    output d_d, d_oe
  );
endinterface

// ### src/rtc_dev.sv
// Clock device end: seconds and minutes counter with busy and fail flags.
`timescale 1ns/100ps
module rtc_dev import rtc_pkg::*; #(
  parameter int PRESCALE = OSC_HZ,
  parameter int BUSY_LEN = BUSY_TICKS
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic nrst_in,
  // Bus from the host.
  rtc_bus_if.dev bus,
  // Oscillator and supply monitor pins.
  input wire logic osc_clk_in,
  input wire logic supply_drop_in,
  // Status.
  output logic [15:0] time_out,
  output logic halted_out,
  output logic busy_out,
  output logic osc_fail_out,
  output logic timer_irq_en_out
);

  if (BUSY_LEN < 1 || BUSY_LEN >= PRESCALE || PRESCALE > 65536) begin
    $error("rtc_dev: prescale parameters out of range");
  end

  typedef struct packed {
    logic osc1;
    logic osc2;
    logic osc3;
    logic drp1;
    logic drp2;
    logic armed;
    logic [1:0] bank;
    logic halt;
    logic fail;
    logic busy;
    logic tmr_en;
    logic [15:0] pre;
    logic [3:0] su;
    logic [3:0] st;
    logic [3:0] mu;
    logic [3:0] mt;
    logic [3:0] rd;
  } rtc_dst_t;

  localparam rtc_dst_t DS_RST = '{halt: RST_HALT, fail: RST_FAIL,
                                  default: '0};

  rtc_dst_t s_ff;
  rtc_dst_t nxt_s;
  logic tick;
  logic sel;
  logic [4:0] c_s;
  logic [4:0] c_t;

  function automatic logic [4:0] bcd_inc(input logic [3:0] d,
                                         input logic [3:0] lim);
    if (d >= lim) begin
      bcd_inc = {1'b1, 4'h0};
    end else begin
      bcd_inc = {1'b0, d + 4'h1};
    end
  endfunction

  function automatic logic [7:0] min_inc(input logic [3:0] mt,
                                         input logic [3:0] mu);
    logic [4:0] u;
    logic [4:0] t;
    u = bcd_inc(mu, 4'h9);
    t = u[4] ? bcd_inc(mt, 4'h5) : {1'b0, mt};
    min_inc = {t[3:0], u[3:0]};
  endfunction

  always_comb begin
    nxt_s = s_ff;
    c_s = '0;
    c_t = '0;
    nxt_s.osc1 = osc_clk_in;
    nxt_s.osc2 = s_ff.osc1;
    nxt_s.osc3 = s_ff.osc2;
    nxt_s.drp1 = supply_drop_in;
    nxt_s.drp2 = s_ff.drp1;
    tick = s_ff.osc2 & ~s_ff.osc3;
    // Selection is refused until the low-active select has been high once.
    if (bus.cs_n) begin
      nxt_s.armed = 1'b1;
    end
    // No gating on the oscillator: access is open as soon as armed.
    sel = s_ff.armed & ~bus.cs_n & bus.cs_hi;
    // With the oscillator stopped no tick arrives and busy stays set.
    if (tick && !s_ff.halt) begin
      if (s_ff.pre == 16'(PRESCALE - 1)) begin
        nxt_s.pre = '0;
        nxt_s.busy = 1'b0;
        c_s = bcd_inc(s_ff.su, 4'h9);
        nxt_s.su = c_s[3:0];
        if (c_s[4]) begin
          c_t = bcd_inc(s_ff.st, 4'h5);
          nxt_s.st = c_t[3:0];
          if (c_t[4]) begin
            {nxt_s.mt, nxt_s.mu} = min_inc(s_ff.mt, s_ff.mu);
          end
        end
      end else begin
        nxt_s.pre = s_ff.pre + 16'h1;
        if (s_ff.pre == 16'(PRESCALE - BUSY_LEN - 1)) begin
          nxt_s.busy = 1'b1;
        end
      end
    end
    if (sel && !bus.wr_n) begin
      if (bus.addr == A_BANK) begin
        nxt_s.bank = bus.data[1:0];
      end else if (s_ff.bank == BANK_TIME) begin
        case (bus.addr)
          A_SEC_U: nxt_s.su = bus.data;
          A_SEC_T: nxt_s.st = bus.data;
          A_MIN_U: nxt_s.mu = bus.data;
          A_MIN_T: nxt_s.mt = bus.data;
          A_CTRL: begin
            nxt_s.halt = bus.data[B_HALT];
            if (bus.data[B_HALT]) begin
              nxt_s.pre = '0;
              nxt_s.busy = 1'b0;
            end
            if (!bus.data[B_FAIL]) begin
              nxt_s.fail = 1'b0;
            end
            // Round to the nearest minute.
            if (bus.data[B_ADJ]) begin
              nxt_s.su = 4'h0;
              nxt_s.st = 4'h0;
              nxt_s.pre = '0;
              nxt_s.busy = 1'b0;
              if (s_ff.st >= 4'h3) begin
                {nxt_s.mt, nxt_s.mu} = min_inc(s_ff.mt, s_ff.mu);
              end
            end
          end
          A_TMR: nxt_s.tmr_en = bus.data[B_TMR_EN];
          default: ;
        endcase
      end
    end
    // A supply drop sets the fail flag and wins over a clear.
    if (s_ff.drp2) begin
      nxt_s.fail = 1'b1;
    end
    nxt_s.rd = '0;
    if (bus.addr == A_BANK) begin
      nxt_s.rd = {2'h0, s_ff.bank};
    end else if (s_ff.bank == BANK_TIME) begin
      case (bus.addr)
        A_SEC_U: nxt_s.rd = s_ff.su;
        A_SEC_T: nxt_s.rd = s_ff.st;
        A_MIN_U: nxt_s.rd = s_ff.mu;
        A_MIN_T: nxt_s.rd = s_ff.mt;
        A_CTRL: begin
          nxt_s.rd[B_HALT] = s_ff.halt;
          nxt_s.rd[B_BUSY] = s_ff.busy;
          nxt_s.rd[B_FAIL] = s_ff.fail;
        end
        A_TMR: nxt_s.rd[B_TMR_EN] = s_ff.tmr_en;
        default: nxt_s.rd = '0;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_ff <= DS_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign bus.d_d = s_ff.rd;
  assign bus.d_oe = sel & ~bus.rd_n;
  assign time_out = {s_ff.mt, s_ff.mu, s_ff.st, s_ff.su};
  assign halted_out = s_ff.halt;
  assign busy_out = s_ff.busy;
  assign osc_fail_out = s_ff.fail;
  assign timer_irq_en_out = s_ff.tmr_en;

endmodule

// ### src/rtc_host.sv
// Host end: power-up, restore check, init, busy-polled read and adjust.
`timescale 1ns/100ps
// Contract
// - Host clears timer enable when unused
// - Host loads time, then releases halt
// - Adjust zeroes seconds, rounds minutes up (here only from 30 s on)
// - Busy clears itself while oscillator runs
// - Stopped oscillator leaves busy set forever
// - Host abandons busy polling after timeout
// - Low-active select held high 50 ms
// - Low-active select high once before access
// - High-active select low before backup
// - Host reads fail flag on power restore
// - Fail set: wait settle, then reinitialise
// - Fail flag set at power-on, drops
// - Fail clear: access at once allowed
// - Bank chosen through common register F
// - Host waits 122 us after halt
module rtc_host import rtc_pkg::*; #(
  parameter int PWRUP_CYCLES = PWRUP_CYC,
  parameter int HALT_WAIT_CYCLES = HALT_WAIT_CYC,
  parameter int POLL_TIMEOUT_CYCLES = POLL_TO_CYC,
  parameter int SETTLE_CYCLES = OSC_SETTLE_CYC
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic nrst_in,
  // Bus towards the device.
  rtc_bus_if.host bus,
  // Requests from user logic.
  input wire logic init_req_in,
  input wire logic read_req_in,
  input wire logic adjust_req_in,
  input wire logic backup_req_in,
  input wire logic timer_irq_en_in,
  input wire logic [15:0] time_in,
  // Results.
  output logic ready_out,
  output logic done_out,
  output logic error_out,
  output logic osc_fail_out,
  output logic [15:0] time_out
);

  if (PWRUP_CYCLES < 1 || HALT_WAIT_CYCLES < 1 ||
      POLL_TIMEOUT_CYCLES < 1 || SETTLE_CYCLES < 1) begin
    $error("rtc_host: timing counts must be at least one cycle");
  end

  // Step numbers of the built-in sequences.
  localparam logic [4:0] PC_FOS = 5'h00;
  localparam logic [4:0] PC_SETTLE = 5'h01;
  localparam logic [4:0] PC_INIT = 5'h02;
  localparam logic [4:0] PC_HALT = 5'h03;
  localparam logic [4:0] PC_HWAIT = 5'h04;
  localparam logic [4:0] PC_TMR = 5'h05;
  localparam logic [4:0] PC_T0 = 5'h06;
  localparam logic [4:0] PC_RUN = 5'h0A;
  localparam logic [4:0] PC_READ = 5'h0B;
  localparam logic [4:0] PC_POLL = 5'h0C;
  localparam logic [4:0] PC_R0 = 5'h0D;
  localparam logic [4:0] PC_RLAST = 5'h10;
  localparam logic [4:0] PC_ADJ = 5'h11;
  localparam logic [4:0] PC_ADJW = 5'h12;

  // Kinds of step.
  localparam logic [1:0] K_WR = 2'h0;
  localparam logic [1:0] K_RD = 2'h1;
  localparam logic [1:0] K_WT = 2'h2;

  typedef struct packed {
    rtc_hst_t st;
    logic [4:0] pc;
    logic rdph;
    logic bk;
    logic cs_n;
    logic cs_hi;
    logic wr_n;
    logic rd_n;
    logic oe;
    logic [3:0] addr;
    logic [3:0] wd;
    logic [31:0] cnt;
    logic [31:0] tocnt;
    logic fail;
    logic done;
    logic err;
    logic [15:0] tm;
  } rtc_hs_t;

  localparam rtc_hs_t HS_RST = '{st: HS_PWR, cs_n: RST_CS_N,
                                 wr_n: 1'b1, rd_n: 1'b1, default: '0};

  rtc_hs_t s_ff;
  rtc_hs_t nxt_s;
  logic go;
  logic fin;
  logic [4:0] gpc;
  logic [5:0] info;
  logic [1:0] ridx;

  // Kind and address of each step.
  function automatic logic [5:0] op_info(input logic [4:0] pc);
    case (pc)
      PC_FOS, PC_POLL: op_info = {K_RD, A_CTRL};
      PC_SETTLE, PC_HWAIT: op_info = {K_WT, 4'h0};
      PC_INIT, PC_READ, PC_ADJ: op_info = {K_WR, A_BANK};
      PC_HALT, PC_RUN, PC_ADJW: op_info = {K_WR, A_CTRL};
      PC_TMR: op_info = {K_WR, A_TMR};
      default: op_info = (pc < PC_RUN) ? {K_WR, 4'(pc - PC_T0)}
          : {K_RD, 4'(pc - PC_R0)};
    endcase
  endfunction

  // Data written by each write step.
  function automatic logic [3:0] wr_data(input logic [4:0] pc,
                                         input logic [15:0] tv,
                                         input logic ten);
    logic [1:0] i;
    i = 2'(pc - PC_T0);
    case (pc)
      PC_INIT, PC_READ, PC_ADJ: wr_data = {2'h0, BANK_TIME};
      PC_HALT: wr_data = D_HALT;
      PC_TMR: wr_data = 4'({3'h0, ten} << B_TMR_EN);
      PC_RUN: wr_data = 4'h0;
      PC_ADJW: wr_data = D_ADJ;
      default: wr_data = tv[i*4 +: 4];
    endcase
  endfunction

  always_comb begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    nxt_s.err = 1'b0;
    go = 1'b0;
    fin = 1'b0;
    gpc = s_ff.pc + 5'h1;
    info = '0;
    ridx = 2'(s_ff.pc - PC_R0);
    case (s_ff.st)
      HS_PWR: begin
        nxt_s.cnt = s_ff.cnt + 32'h1;
        // The low-active select stays high for the whole wait.
        if (s_ff.cnt == 32'(PWRUP_CYCLES - 1)) begin
          nxt_s.cs_n = 1'b0;
          nxt_s.cs_hi = 1'b1;
          go = 1'b1;
          gpc = PC_FOS;
        end
      end
      HS_IDLE: begin
        if (backup_req_in) begin
          nxt_s.cs_hi = 1'b0;
          nxt_s.bk = 1'b1;
        end else if (s_ff.bk) begin
          nxt_s.bk = 1'b0;
          nxt_s.cs_hi = 1'b1;
          go = 1'b1;
          gpc = PC_FOS;
        end else if (init_req_in) begin
          go = 1'b1;
          gpc = PC_INIT;
        end else if (read_req_in) begin
          go = 1'b1;
          gpc = PC_READ;
          nxt_s.tocnt = '0;
        end else if (adjust_req_in) begin
          go = 1'b1;
          gpc = PC_ADJ;
        end
      end
      HS_WR: begin
        // The strobe rests one cycle before the next step starts.
        nxt_s.wr_n = 1'b1;
        nxt_s.oe = 1'b0;
        nxt_s.cnt = s_ff.cnt + 32'h1;
        fin = s_ff.cnt[0] & ((s_ff.pc == PC_RUN) | (s_ff.pc == PC_ADJW));
        go = s_ff.cnt[0] & ~fin;
      end
      HS_RD: begin
        if (s_ff.pc == PC_POLL) begin
          nxt_s.tocnt = s_ff.tocnt + 32'h1;
        end
        if (!s_ff.rdph) begin
          // A read straight after a read rests its strobe one cycle first.
          nxt_s.rdph = ~s_ff.rd_n;
          nxt_s.rd_n = 1'b0;
        end else begin
          nxt_s.rd_n = 1'b1;
          nxt_s.rdph = 1'b0;
          go = 1'b1;
          if (s_ff.pc == PC_FOS) begin
            nxt_s.fail = bus.data[B_FAIL];
            // Fail clear: done at once; set: settle wait then full init.
            if (!bus.data[B_FAIL]) begin
              go = 1'b0;
              fin = 1'b1;
            end
          end else if (s_ff.pc == PC_POLL) begin
            if (bus.data[B_BUSY]) begin
              if (s_ff.tocnt >= 32'(POLL_TIMEOUT_CYCLES)) begin
                go = 1'b0;
                nxt_s.err = 1'b1;
                nxt_s.st = HS_IDLE;
              end else begin
                gpc = PC_POLL;
              end
            end
          end else begin
            nxt_s.tm[ridx*4 +: 4] = bus.data;
            fin = (s_ff.pc == PC_RLAST);
            go = ~fin;
          end
        end
      end
      HS_WT: begin
        nxt_s.cnt = s_ff.cnt + 32'h1;
        if (s_ff.pc == PC_SETTLE) begin
          go = (s_ff.cnt == 32'(SETTLE_CYCLES - 1));
        end else begin
          go = (s_ff.cnt == 32'(HALT_WAIT_CYCLES - 1));
        end
      end
      default: nxt_s.st = HS_IDLE;
    endcase
    if (fin) begin
      nxt_s.st = HS_IDLE;
      nxt_s.done = 1'b1;
    end else if (go) begin
      info = op_info(gpc);
      nxt_s.pc = gpc;
      nxt_s.addr = info[3:0];
      nxt_s.cnt = '0;
      nxt_s.rdph = 1'b0;
      case (info[5:4])
        K_WR: begin
          nxt_s.st = HS_WR;
          nxt_s.wr_n = 1'b0;
          nxt_s.oe = 1'b1;
          nxt_s.wd = wr_data(gpc, time_in, timer_irq_en_in);
        end
        K_RD: begin
          nxt_s.st = HS_RD;
          nxt_s.rd_n = (s_ff.st == HS_RD);
        end
        default: nxt_s.st = HS_WT;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_ff <= HS_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign bus.cs_n = s_ff.cs_n;
  assign bus.cs_hi = s_ff.cs_hi;
  assign bus.wr_n = s_ff.wr_n;
  assign bus.rd_n = s_ff.rd_n;
  assign bus.addr = s_ff.addr;
  assign bus.h_d = s_ff.wd;
  assign bus.h_oe = s_ff.oe;
  assign ready_out = (s_ff.st == HS_IDLE) & ~backup_req_in & ~s_ff.bk;
  assign done_out = s_ff.done;
  assign error_out = s_ff.err;
  assign osc_fail_out = s_ff.fail;
  assign time_out = s_ff.tm;

endmodule

// ### tb/rtc_bus_props.sv
// Checker for the bus between the host and device ends.
`timescale 1ns/100ps
// Defaults match the shortened host timing that the bench runs.
module rtc_bus_props import rtc_pkg::*; #(
  parameter int PWRUP_CYCLES = 20,
  parameter int HALT_WAIT_CYCLES = 5,
  parameter int POLL_TIMEOUT_CYCLES = 200
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic nrst_in,
  // Bus signals.
  input wire logic cs_n,
  input wire logic cs_hi,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [3:0] addr,
  input wire logic [DW-1:0] h_d,
  input wire logic h_oe,
  input wire logic d_oe,
  input wire logic [DW-1:0] data
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  logic wr_ev;
  logic seen_hi, pend, cs_hi_q, rd_q, busy_q, halt_p;
  logic [1:0] bank;
  logic [3:0] tw;
  int pwr_cnt, halt_cnt, poll_n;
  assign wr_ev = !wr_n && !cs_n && cs_hi;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      seen_hi <= 1'b0;
      pend <= 1'b0;
      cs_hi_q <= 1'b0;
      rd_q <= 1'b1;
      busy_q <= 1'b0;
      halt_p <= 1'b0;
      bank <= 2'h0;
      tw <= 4'h0;
      pwr_cnt <= 0;
      halt_cnt <= 0;
      poll_n <= 0;
    end else begin
      seen_hi <= seen_hi | cs_n;
      cs_hi_q <= cs_hi;
      rd_q <= rd_n;
      if (pwr_cnt < PWRUP_CYCLES) pwr_cnt <= pwr_cnt + 1;
      if (halt_cnt < HALT_WAIT_CYCLES) halt_cnt <= halt_cnt + 1;
      if (cs_hi && !cs_hi_q) pend <= 1'b1;
      else if (!rd_n || !wr_n) pend <= 1'b0;
      if (!rd_n && !rd_q && addr == A_CTRL) busy_q <= data[B_BUSY];
      if (wr_ev) poll_n <= 0;
      else if (!rd_n && rd_q && addr == A_CTRL && busy_q) begin
        poll_n <= poll_n + 1;
      end
      if (wr_ev) begin
        halt_p <= 1'b0;
        if (addr == A_BANK) bank <= h_d[1:0];
        if (addr <= A_MIN_T) tw[addr[1:0]] <= 1'b1;
        if (addr == A_CTRL && h_d[B_HALT]) begin
          halt_p <= 1'b1;
          halt_cnt <= 0;
          tw <= 4'h0;
        end
      end
    end
  end
  sequence wr_step_s;
    !wr_n && h_oe ##1 wr_n && !h_oe;
  endsequence
  sequence rd_step_s;
    !rd_n && d_oe ##1 !rd_n && d_oe ##1 rd_n;
  endsequence
  pwrup_hold_a: assert property (
    pwr_cnt < PWRUP_CYCLES - 1 |-> cs_n && !cs_hi)
    else $error("select asserted during power-up hold");
  select_armed_a: assert property (
    !wr_n || !rd_n |-> seen_hi)
    else $error("access before select went high");
  first_read_a: assert property (
    pend && (!rd_n || !wr_n) |-> !rd_n && addr == A_CTRL)
    else $error("first access is not a status read");
  bank_zero_a: assert property (
    wr_ev && addr != A_BANK |-> bank == BANK_TIME)
    else $error("write without bank zero selected");
  start_order_a: assert property (
    wr_ev && addr == A_CTRL && h_d == 4'h0 |-> tw == 4'hF)
    else $error("clock started before time loaded");
  halt_wait_a: assert property (
    wr_ev && halt_p |-> halt_cnt >= HALT_WAIT_CYCLES - 1)
    else $error("write too soon after halt");
  write_pulse_a: assert property ($fell(wr_n) |-> wr_step_s)
    else $error("write strobe shape wrong");
  read_hold_a: assert property ($fell(rd_n) |-> rd_step_s)
    else $error("read strobe shape wrong");
  busy_gate_a: assert property (
    !rd_n && rd_q && addr <= A_MIN_T |-> !busy_q)
    else $error("time read while busy");
  poll_limit_a: assert property (
    poll_n <= POLL_TIMEOUT_CYCLES / 2 + 2)
    else $error("busy polling not abandoned");
endmodule

// ### tb/tb_top.sv
// Self-checking bench joining the host and device ends.
`timescale 1ns/100ps
module tb_top import rtc_pkg::*;;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic osc_clk_in = 1'b0;
  logic osc_run = 1'b0;
  logic supply_drop_in = 1'b0;
  logic init_req_in = 1'b0;
  logic read_req_in = 1'b0;
  logic adjust_req_in = 1'b0;
  logic backup_req_in = 1'b0;
  logic timer_irq_en_in = 1'b0;
  logic [15:0] time_in = 16'h0000;
  logic ready_out, done_out, error_out, h_fail;
  logic d_halt, d_busy, d_fail, d_ten;
  logic [15:0] h_time, d_time;
  logic [15:0] corner [4] = '{16'h5929, 16'h5930, 16'h5959, 16'h0945};
  int failures = 0;
  int comparisons = 0;
  rtc_bus_if bus ();
  always #5 clk_in = ~clk_in;
  always #30 osc_clk_in = osc_run ? ~osc_clk_in : osc_clk_in;
  rtc_host #(.PWRUP_CYCLES(20), .HALT_WAIT_CYCLES(5),
    .POLL_TIMEOUT_CYCLES(200), .SETTLE_CYCLES(10)) rtc_host_inst (
    .clk_in(clk_in), .nrst_in(nrst_in), .bus(bus),
    .init_req_in(init_req_in), .read_req_in(read_req_in),
    .adjust_req_in(adjust_req_in), .backup_req_in(backup_req_in),
    .timer_irq_en_in(timer_irq_en_in), .time_in(time_in),
    .ready_out(ready_out), .done_out(done_out), .error_out(error_out),
    .osc_fail_out(h_fail), .time_out(h_time));
  rtc_dev #(.PRESCALE(16)) rtc_dev_inst (
    .clk_in(clk_in), .nrst_in(nrst_in), .bus(bus),
    .osc_clk_in(osc_clk_in), .supply_drop_in(supply_drop_in),
    .time_out(d_time), .halted_out(d_halt), .busy_out(d_busy),
    .osc_fail_out(d_fail), .timer_irq_en_out(d_ten));
  rtc_bus_props rtc_bus_props_inst (
    .clk_in(clk_in), .nrst_in(nrst_in), .cs_n(bus.cs_n),
    .cs_hi(bus.cs_hi), .wr_n(bus.wr_n), .rd_n(bus.rd_n),
    .addr(bus.addr), .h_d(bus.h_d), .h_oe(bus.h_oe), .d_oe(bus.d_oe),
    .data(bus.data));
  task automatic end_sim();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(inout int n);
    @(negedge clk_in);
    n++;
    if (n > 5000) begin
      failures++;
      $display("wait limit reached at %0t", $time);
      end_sim();
    end
  endtask
  // Kind 0 init, 1 read, 2 adjust, 3 only waits for the restore to end.
  task automatic req(input int k, output logic err);
    int n;
    n = 0;
    if (k < 3) begin
      while (ready_out !== 1'b1) step(n);
      {init_req_in, read_req_in, adjust_req_in} = 3'h4 >> k;
      step(n);
      {init_req_in, read_req_in, adjust_req_in} = 3'h0;
    end
    while (done_out !== 1'b1 && error_out !== 1'b1) step(n);
    err = error_out;
  endtask
  function automatic logic [15:0] adj_exp(input logic [15:0] t);
    logic [15:0] r;
    r = {t[15:8], 8'h00};
    if (t[7:4] >= 4'h3) begin
      if (t[11:8] == 4'h9) begin
        r[11:8] = 4'h0;
        r[15:12] = (t[15:12] == 4'h5) ? 4'h0 : t[15:12] + 4'h1;
      end else begin
        r[11:8] = t[11:8] + 4'h1;
      end
    end
    return r;
  endfunction
  function automatic logic [15:0] rnd_time();
    return {4'($urandom % 6), 4'($urandom % 10), 4'($urandom % 6),
      4'($urandom % 10)};
  endfunction
  initial begin
    logic err;
    logic [15:0] t;
    int n;
    void'($urandom(32'hF54F));
    time_in = rnd_time();
    repeat (12) @(negedge clk_in);
    nrst_in = 1'b1;
    req(3, err);
    chk(16'(h_fail), 16'h0001);
    chk(d_time, time_in);
    chk(16'(d_halt), 16'h0000);
    chk(16'(d_fail), 16'h0000);
    $display("test power_up done");
    for (int i = 0; i < 8; i++) begin
      t = (i < 4) ? corner[i] : rnd_time();
      time_in = t;
      timer_irq_en_in = i[0];
      req(0, err);
      chk(16'(d_ten), 16'(i[0]));
      req(1, err);
      chk(h_time, t);
      req(2, err);
      chk(d_time, adj_exp(t));
    end
    $display("test adjust done");
    osc_run = 1'b1;
    for (int i = 0; i < 8; i++) begin
      n = 0;
      while (i[0] && d_busy !== 1'b1) step(n);
      req(1, err);
      chk(16'(err), 16'h0000);
      chk(h_time, d_time);
      repeat ($urandom % 40) @(negedge clk_in);
    end
    $display("test busy_poll done");
    n = 0;
    while (d_busy !== 1'b1) step(n);
    osc_run = 1'b0;
    req(1, err);
    chk(16'(err), 16'h0001);
    chk(16'(d_busy), 16'h0001);
    $display("test busy_stuck done");
    time_in = rnd_time();
    t = time_in;
    req(0, err);
    for (int i = 0; i < 2; i++) begin
      backup_req_in = 1'b1;
      repeat (4) @(negedge clk_in);
      chk(16'(bus.cs_hi), 16'h0000);
      supply_drop_in = i[0];
      repeat (4) @(negedge clk_in);
      supply_drop_in = 1'b0;
      time_in = rnd_time();
      backup_req_in = 1'b0;
      req(3, err);
      chk(16'(h_fail), 16'(i[0]));
      chk(d_time, i[0] ? time_in : t);
    end
    $display("test backup done");
    end_sim();
  end
endmodule
